// file: core/rxq_pkg.sv
// Purpose: constants for the receive event and interrupt status queue block
// Assumes: 16-bit register words, low six bits of each word except the length word carry a register number
// Notes: all offsets are byte addresses of the memory page or the I/O window
package rxq_pkg;
	localparam logic [15:0] OFS_RX_CFG = 16'h0102;
	localparam logic [15:0] OFS_QUEUE = 16'h0120;
	localparam logic [15:0] OFS_RX_EVENT = 16'h0124;
	localparam logic [15:0] OFS_RX_STATUS = 16'h0400;
	localparam logic [15:0] OFS_RX_LENGTH = 16'h0402;
	localparam logic [15:0] OFS_IO_QUEUE = 16'h0008;
	localparam logic [5:0] ID_RX_CFG = 6'h03;
	localparam logic [5:0] ID_RX_EVENT = 6'h04;
	localparam logic [5:0] ID_TX_EVENT = 6'h08;
	localparam logic [5:0] ID_BUF_EVENT = 6'h0C;
	localparam logic [5:0] ID_MISS_OVF = 6'h10;
	localparam logic [5:0] ID_COL_OVF = 6'h12;
	localparam logic [15:0] RX_CFG_RESET = 16'h0003;
	localparam logic [15:0] RX_CFG_WR_MASK = 16'h7F80;
	localparam int CFG_SKIP = 6;
	localparam int CFG_STREAM = 7;
	localparam int CFG_GOOD_IE = 8;
	localparam int CFG_DMA_ONLY = 9;
	localparam int CFG_AUTO_DMA = 10;
	localparam int CFG_KEEP_FCS = 11;
	localparam int CFG_FCS_IE = 12;
	localparam int CFG_SHORT_IE = 13;
	localparam int CFG_LONG_IE = 14;
	localparam int EV_INDIVIDUAL_HASH_HIT = 6;
	localparam int EV_DRIBBLE = 7;
	localparam int EV_GOOD = 8;
	localparam int EV_HASHED = 9;
	localparam int EV_STATION = 10;
	localparam int EV_BCAST = 11;
	localparam int EV_FCS = 12;
	localparam int EV_SHORT = 13;
	localparam int EV_LONG = 14;
	localparam int EV_WAKE = 15;
	localparam logic [15:0] LEN_DISCARD = 16'h0008;
	localparam logic [15:0] LEN_MIN = 16'h0040;
	localparam logic [15:0] LEN_MAX = 16'h05EE;
	localparam logic [15:0] LEN_FCS = 16'h0004;
	localparam int NUM_SRC = 5;
endpackage

// file: core/rxq_top.sv
// Purpose: receive configuration, receive event flags and interrupt status queue
// Assumes: all inputs but rstn synchronous to sys_clk; one frame result per handshake
// Notes: address filter, station address and hash logic live upstream
`timescale 1ns/1ps
`default_nettype none
module rxq_top #(
	parameter int DEPTH = 2,
	parameter int LEN_W = 11
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// host register port
	input wire logic reg_mem_mode,
	input wire logic [15:0] reg_addr,
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	output logic irq,
	// configuration memory load
	input wire logic cfg_mem_load,
	input wire logic [15:0] cfg_mem_data,
	// receive filter options held elsewhere
	input wire logic accept_individual_hash,
	input wire logic accept_station_addr,
	input wire logic accept_all_ones_addr,
	input wire logic dma_switch_cond,
	// frame result from the receiver
	input wire logic frm_valid,
	output logic frm_ready,
	input wire logic [15:0] frm_len,
	input wire logic frm_fcs_bad,
	input wire logic frm_dribble,
	input wire logic frm_hashed,
	input wire logic [5:0] frm_hash_index,
	input wire logic frm_station_match,
	input wire logic frm_all_ones,
	input wire logic frm_wake,
	// frame descriptor to the buffer manager
	output logic desc_valid,
	input wire logic desc_ready,
	output logic [LEN_W-1:0] desc_len,
	output logic desc_good,
	output logic desc_use_dma,
	output logic desc_stream,
	output logic skip_frame,
	// other queue sources
	input wire logic tx_event_set,
	input wire logic [9:0] tx_event_bits,
	input wire logic tx_event_int,
	input wire logic buf_event_set,
	input wire logic [9:0] buf_event_bits,
	input wire logic buf_event_int,
	input wire logic miss_ovf,
	input wire logic [9:0] miss_count,
	input wire logic col_ovf,
	input wire logic [9:0] col_count
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	localparam int DW = LEN_W + 3;
	localparam int NS = rxq_pkg::NUM_SRC;

	logic [15:0] rx_cfg;
	logic [15:0] rx_status;
	logic [LEN_W-1:0] rx_length;
	logic [9:0] src_word [NS];
	logic [NS-1:0] pend;
	logic [NS-1:0] next_pend;
	logic [NS-1:0] src_load;
	logic [NS-1:0] src_or;
	logic [NS-1:0] src_int;
	logic [NS-1:0] src_clr;
	logic [9:0] src_data [NS];
	logic [5:0] src_id [NS];

	logic take;
	logic keep;
	logic is_short;
	logic is_long;
	logic is_good;
	logic [15:0] kept_len;
	logic [15:0] store_len;
	logic [15:0] new_ev;
	logic rx_int;
	logic use_dma;
	logic stream_ok;

	logic q_any;
	logic [2:0] q_sel;
	logic rd_mem;
	logic rd_queue;
	logic rd_event;
	logic wr_cfg;
	logic [15:0] next_rdata;

	logic [DW-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [CW-1:0] count;
	logic [DW-1:0] new_desc;
	logic push;
	logic pop;
	logic [PW-1:0] next_wr_ptr;
	logic [PW-1:0] next_rd_ptr;
	logic [CW-1:0] next_count;
	logic [DW-1:0] next_head;

	// host access decode
	always_comb begin
		rd_mem = reg_rd && reg_mem_mode;
		rd_queue = reg_rd && (reg_mem_mode ? (reg_addr == rxq_pkg::OFS_QUEUE)
			: (reg_addr == rxq_pkg::OFS_IO_QUEUE));
		rd_event = rd_mem && (reg_addr == rxq_pkg::OFS_RX_EVENT);
		wr_cfg = reg_wr && reg_mem_mode && (reg_addr == rxq_pkg::OFS_RX_CFG);
	end

	// frame classification, lengths counted with the FCS
	always_comb begin
		take = frm_valid && frm_ready;
		keep = frm_len >= rxq_pkg::LEN_DISCARD;
		is_short = frm_len < rxq_pkg::LEN_MIN;
		is_long = frm_len > rxq_pkg::LEN_MAX;
		is_good = !frm_fcs_bad && !is_short && !is_long;
		// bytes beyond the maximum never reach the buffer
		kept_len = is_long ? rxq_pkg::LEN_MAX : frm_len;
		store_len = rx_cfg[rxq_pkg::CFG_KEEP_FCS] ? kept_len
			: kept_len - rxq_pkg::LEN_FCS;
	end

	// event word for one frame
	always_comb begin
		new_ev = 16'h0000;
		new_ev[5:0] = rxq_pkg::ID_RX_EVENT;
		new_ev[rxq_pkg::EV_INDIVIDUAL_HASH_HIT] = is_good && accept_individual_hash && frm_hashed;
		new_ev[rxq_pkg::EV_DRIBBLE] = frm_dribble;
		new_ev[rxq_pkg::EV_GOOD] = is_good;
		new_ev[rxq_pkg::EV_HASHED] = frm_hashed;
		if (frm_hashed && is_good) begin
			new_ev[15:10] = frm_hash_index;
		end else begin
			new_ev[rxq_pkg::EV_STATION] = frm_station_match && is_good
				&& accept_station_addr;
			new_ev[rxq_pkg::EV_BCAST] = frm_all_ones && is_good
				&& accept_all_ones_addr;
			new_ev[rxq_pkg::EV_FCS] = frm_fcs_bad;
			new_ev[rxq_pkg::EV_SHORT] = is_short;
			new_ev[rxq_pkg::EV_LONG] = is_long;
			new_ev[rxq_pkg::EV_WAKE] = frm_wake;
		end
		// long-frame interrupt ignores FCS state
		rx_int = (is_good && rx_cfg[rxq_pkg::CFG_GOOD_IE])
			|| (frm_fcs_bad && rx_cfg[rxq_pkg::CFG_FCS_IE])
			|| (is_short && rx_cfg[rxq_pkg::CFG_SHORT_IE])
			|| (is_long && rx_cfg[rxq_pkg::CFG_LONG_IE]);
	end

	// queue head: lowest numbered pending source first
	always_comb begin
		q_any = |pend;
		q_sel = 3'h0;
		for (int i = NS - 1; i >= 0; i--) begin
			if (pend[i]) begin
				q_sel = 3'(i);
			end
		end
	end

	// per-source load, merge and clear terms
	always_comb begin
		src_id[0] = rxq_pkg::ID_RX_EVENT;
		src_id[1] = rxq_pkg::ID_TX_EVENT;
		src_id[2] = rxq_pkg::ID_BUF_EVENT;
		src_id[3] = rxq_pkg::ID_MISS_OVF;
		src_id[4] = rxq_pkg::ID_COL_OVF;
		src_load = {col_ovf, miss_ovf, buf_event_set, tx_event_set, take && keep};
		// event registers accumulate, rx and counter reports replace
		src_or = 5'b00110;
		src_int = {col_ovf, miss_ovf, buf_event_set && buf_event_int,
			tx_event_set && tx_event_int, take && keep && rx_int};
		src_data[0] = new_ev[15:6];
		src_data[1] = tx_event_bits;
		src_data[2] = buf_event_bits;
		src_data[3] = miss_count;
		src_data[4] = col_count;
		for (int i = 0; i < NS; i++) begin
			src_clr[i] = rd_queue && q_any && (q_sel == 3'(i));
		end
		src_clr[0] = src_clr[0] || rd_event;
		for (int i = 0; i < NS; i++) begin
			// a new event in the clearing cycle survives
			next_pend[i] = (pend[i] && !src_clr[i]) || src_int[i];
		end
	end

	// source registers, read clears them
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < NS; i++) begin
				src_word[i] <= 10'h000;
			end
		end else begin
			for (int i = 0; i < NS; i++) begin
				if (src_load[i] && src_or[i]) begin
					src_word[i] <= (src_clr[i] ? 10'h000 : src_word[i]) | src_data[i];
				end else if (src_load[i]) begin
					src_word[i] <= src_data[i];
				end else if (src_clr[i]) begin
					src_word[i] <= 10'h000;
				end
			end
		end
	end

	// pending flags
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pend <= '0;
		end else begin
			pend <= next_pend;
		end
	end

	// pin follows the next pending set, so it rises with the event
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			irq <= 1'b0;
		end else begin
			irq <= |next_pend;
		end
	end

	// status copy survives event reads
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rx_status <= 16'h0000;
		end else if (take && keep) begin
			rx_status <= new_ev;
		end
	end

	// a bad frame leaves the last good length in place
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rx_length <= '0;
		end else if (take && keep && is_good) begin
			rx_length <= LEN_W'(store_len);
		end
	end

	// receive configuration
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rx_cfg <= rxq_pkg::RX_CFG_RESET;
		end else if (wr_cfg) begin
			rx_cfg <= (reg_wdata & rxq_pkg::RX_CFG_WR_MASK) | rxq_pkg::RX_CFG_RESET;
		end else if (cfg_mem_load) begin
			rx_cfg <= (cfg_mem_data & rxq_pkg::RX_CFG_WR_MASK) | rxq_pkg::RX_CFG_RESET;
		end
	end

	// skip is act-once; ignored under DMA-only to protect the DMA ring
	// dma-only already held or written in the same word both block it
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			skip_frame <= 1'b0;
		end else begin
			skip_frame <= wr_cfg && reg_wdata[rxq_pkg::CFG_SKIP]
				&& !rx_cfg[rxq_pkg::CFG_DMA_ONLY]
				&& !reg_wdata[rxq_pkg::CFG_DMA_ONLY];
		end
	end

	// read data mux; i/o mode reaches the queue only
	always_comb begin
		next_rdata = 16'h0000;
		if (rd_queue) begin
			next_rdata = q_any ? {src_word[q_sel], src_id[q_sel]} : 16'h0000;
		end else if (rd_mem) begin
			unique case (reg_addr)
				rxq_pkg::OFS_RX_CFG: next_rdata = rx_cfg;
				rxq_pkg::OFS_RX_EVENT: next_rdata = {src_word[0], rxq_pkg::ID_RX_EVENT};
				rxq_pkg::OFS_RX_STATUS: next_rdata = rx_status;
				rxq_pkg::OFS_RX_LENGTH: next_rdata = 16'(rx_length);
				default: next_rdata = 16'h0000;
			endcase
		end
	end

	// read data holds until the next read, so a slow host still sees it
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end
	end

	// answer one cycle after the strobe
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
		end
	end

	// descriptor buffer control
	always_comb begin
		// dma-only outranks the automatic switch
		use_dma = rx_cfg[rxq_pkg::CFG_DMA_ONLY]
			|| (rx_cfg[rxq_pkg::CFG_AUTO_DMA] && dma_switch_cond);
		// streaming only takes effect when dma-only or the automatic DMA switch is set
		stream_ok = rx_cfg[rxq_pkg::CFG_STREAM] && (rx_cfg[rxq_pkg::CFG_DMA_ONLY]
			|| rx_cfg[rxq_pkg::CFG_AUTO_DMA]);
		new_desc = {is_good, use_dma, stream_ok, LEN_W'(store_len)};
		push = take && keep;
		pop = desc_valid && desc_ready;
		next_wr_ptr = push ? ((wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
		next_rd_ptr = pop ? ((rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
		next_count = count + CW'(push) - CW'(pop);
		next_head = (push && (wr_ptr == next_rd_ptr)) ? new_desc : mem[next_rd_ptr];
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= '0;
			end
		end else if (push) begin
			mem[wr_ptr] <= new_desc;
		end
	end

	// buffer pointers and fill count
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end

	// registered handshake so stalls reach the receiver
	// ready drops exactly when the buffer fills: full is seen from next_count
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			frm_ready <= 1'b0;
			desc_valid <= 1'b0;
		end else begin
			frm_ready <= next_count != CW'(DEPTH);
			desc_valid <= next_count != '0;
		end
	end

	// head entry copied out so every descriptor field is a flop
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			desc_len <= '0;
			desc_good <= 1'b0;
			desc_use_dma <= 1'b0;
			desc_stream <= 1'b0;
		end else begin
			{desc_good, desc_use_dma, desc_stream, desc_len} <= next_head;
		end
	end
endmodule
`default_nettype wire

// file: dv/rxq_desc_sink.sv
// Purpose: buffer manager stand-in taking frame descriptors
// Assumes: descriptor handshake valid and ready on sys_clk
// Notes: stalls at random; hold forces a long stall to fill the fifo
`timescale 1ns/1ps
`default_nettype none
module rxq_desc_sink (
	// clock and control
	input wire logic sys_clk,
	input wire logic hold,
	// descriptor
	input wire logic desc_valid,
	input wire logic [10:0] desc_len,
	input wire logic desc_good,
	input wire logic desc_use_dma,
	input wire logic desc_stream,
	output logic desc_ready,
	// capture
	output logic [13:0] last,
	output int taken
);
	int seed = 88050;
	initial begin
		desc_ready = 1'b0;
		taken = 0;
		last = 14'h0000;
	end
	// stall about a quarter of cycles so descriptors back up
	always @(negedge sys_clk) begin
		desc_ready <= !hold && (($random(seed) & 3) != 0);
	end
	always @(posedge sys_clk) begin
		if (desc_valid && desc_ready) begin
			last <= {desc_stream, desc_use_dma, desc_good, desc_len};
			taken <= taken + 1;
		end
	end
endmodule
`default_nettype wire

// file: dv/rxq_properties.sv
// Purpose: port assertions for the receive event queue block
// Assumes: one clock, rstn asynchronous active low
// Notes: sees only rxq_top ports, attached by bind below
`timescale 1ns/1ps
`default_nettype none
module rxq_properties (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// host register port
	input wire logic reg_mem_mode,
	input wire logic [15:0] reg_addr,
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_rvalid,
	// configuration memory load
	input wire logic cfg_mem_load,
	input wire logic [15:0] cfg_mem_data,
	// frame in, descriptor out
	input wire logic frm_valid,
	input wire logic frm_ready,
	input wire logic [15:0] frm_len,
	input wire logic desc_valid,
	input wire logic skip_frame
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	logic q_rd;
	logic cfg_rd;
	logic ev_rd;
	logic dma_only_held;
	// dma-only bit as last written or loaded from config memory
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			dma_only_held <= 1'b0;
		end else if (reg_wr && reg_mem_mode && reg_addr == rxq_pkg::OFS_RX_CFG) begin
			dma_only_held <= reg_wdata[rxq_pkg::CFG_DMA_ONLY];
		end else if (cfg_mem_load) begin
			dma_only_held <= cfg_mem_data[rxq_pkg::CFG_DMA_ONLY];
		end
	end
	assign q_rd = reg_rd && (reg_mem_mode ? reg_addr == rxq_pkg::OFS_QUEUE
		: reg_addr == rxq_pkg::OFS_IO_QUEUE);
	assign cfg_rd = reg_rd && reg_mem_mode && reg_addr == rxq_pkg::OFS_RX_CFG;
	assign ev_rd = reg_rd && reg_mem_mode && reg_addr == rxq_pkg::OFS_RX_EVENT;
	sequence s_skip_wr;
		reg_wr && reg_mem_mode && reg_addr == rxq_pkg::OFS_RX_CFG && reg_wdata[6];
	endsequence
	sequence s_one_pulse;
		skip_frame ##1 !skip_frame;
	endsequence
	a_queue_answer: assert property (q_rd |=> reg_rvalid)
		else $error("queue read not answered");
	a_queue_empty: assert property ($past(q_rd) && reg_rdata[5:0] == 6'h00 |-> reg_rdata == 16'h0000)
		else $error("empty queue word not zero");
	a_queue_number: assert property ($past(q_rd) |-> reg_rdata[5:0] inside {6'h00, 6'h04, 6'h08,
		6'h0C, 6'h10, 6'h12})
		else $error("queue source number illegal");
	a_cfg_ident: assert property ($past(cfg_rd) |-> reg_rdata[5:0] == 6'h03)
		else $error("config ident bits wrong");
	a_event_ident: assert property ($past(ev_rd) |-> reg_rdata[5:0] == 6'h04)
		else $error("event ident bits wrong");
	a_skip_once: assert property (s_skip_wr ##0 (!reg_wdata[9] && !dma_only_held)
		|=> s_one_pulse)
		else $error("skip pulse missing or long");
	a_skip_dma_only: assert property (s_skip_wr ##0 (reg_wdata[9] || dma_only_held)
		|=> !skip_frame)
		else $error("skip while dma only");
	a_short_dropped: assert property (frm_valid && frm_ready && frm_len < 16'h0008 && !desc_valid
		|=> !desc_valid)
		else $error("short frame described");
endmodule
bind rxq_top rxq_properties u_rxq_properties (.sys_clk, .rstn, .reg_mem_mode, .reg_addr, .reg_rd,
	.reg_wr, .reg_wdata, .reg_rdata, .reg_rvalid, .cfg_mem_load, .cfg_mem_data, .frm_valid,
	.frm_ready, .frm_len, .desc_valid, .skip_frame);
`default_nettype wire

// file: dv/rxq_top_test.sv
// Purpose: self-checking bench for the receive event queue block
// Assumes: inputs change at falling edge, tasks start and end there
// Notes: random frames from a fixed seed plus boundary lengths
`timescale 1ns/1ps
`default_nettype none
module rxq_top_test;
	logic sys_clk, rstn, reg_mem_mode, reg_rd, reg_wr, reg_rvalid, irq, cfg_mem_load, hold;
	logic [15:0] reg_addr, reg_wdata, reg_rdata, cfg_mem_data, frm_len, cfg, e, d;
	logic accept_individual_hash, accept_station_addr, accept_all_ones_addr, dma_switch_cond;
	logic frm_valid, frm_ready, frm_fcs_bad, frm_dribble, frm_hashed, frm_station_match;
	logic frm_all_ones, frm_wake, desc_valid, desc_ready, desc_good, desc_use_dma, desc_stream;
	logic skip_frame, tx_event_set, tx_event_int, buf_event_set, buf_event_int, miss_ovf, col_ovf;
	logic [9:0] tx_event_bits, buf_event_bits, miss_count, col_count;
	logic [5:0] frm_hash_index;
	logic [10:0] desc_len, xl;
	logic [13:0] last;
	logic [15:0] lens [8] = '{16'h0007, 16'h0008, 16'h003F, 16'h0040, 16'h05EE, 16'h05EF,
		16'h0006, 16'h07D0};
	logic [15:0] q [5];
	logic en, lg;
	int taken, n, seed = 88050, fail_count = 0, checks_done = 0;
	rxq_top u_rxq_top (.sys_clk, .rstn, .reg_mem_mode, .reg_addr, .reg_rd, .reg_wr, .reg_wdata,
		.reg_rdata, .reg_rvalid, .irq, .cfg_mem_load, .cfg_mem_data, .accept_individual_hash,
		.accept_station_addr, .accept_all_ones_addr, .dma_switch_cond, .frm_valid, .frm_ready,
		.frm_len, .frm_fcs_bad, .frm_dribble, .frm_hashed, .frm_hash_index, .frm_station_match,
		.frm_all_ones, .frm_wake, .desc_valid, .desc_ready, .desc_len, .desc_good, .desc_use_dma,
		.desc_stream, .skip_frame, .tx_event_set, .tx_event_bits, .tx_event_int, .buf_event_set,
		.buf_event_bits, .buf_event_int, .miss_ovf, .miss_count, .col_ovf, .col_count);
	rxq_desc_sink u_rxq_desc_sink (.sys_clk, .hold, .desc_valid, .desc_len, .desc_good,
		.desc_use_dma, .desc_stream, .desc_ready, .last, .taken);
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] x);
		checks_done++;
		if (s !== x) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic rdr(input logic m, input logic [15:0] a);
		reg_mem_mode = m;
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge sys_clk);
		reg_rd = 1'b0;
		d = reg_rdata;
		@(negedge sys_clk);
	endtask
	task automatic wrr(input logic [15:0] w);
		reg_mem_mode = 1'b1;
		reg_addr = 16'h0102;
		reg_wdata = w;
		reg_wr = 1'b1;
		@(negedge sys_clk);
		reg_wr = 1'b0;
	endtask
	task automatic frame();
		frm_valid = 1'b1;
		for (int k = 0; k < 40 && !frm_ready; k++) @(negedge sys_clk);
		@(negedge sys_clk);
		frm_valid = 1'b0;
		@(negedge sys_clk);
	endtask
	function automatic logic [15:0] exp_ev();
		logic g;
		logic [15:0] x;
		g = !frm_fcs_bad && frm_len >= 16'h0040 && frm_len <= 16'h05EE;
		x = {frm_wake, frm_len > 16'h05EE, frm_len < 16'h0040, frm_fcs_bad,
			g && frm_all_ones && accept_all_ones_addr, g && frm_station_match && accept_station_addr,
			frm_hashed, g, frm_dribble, g && frm_hashed && accept_individual_hash, 6'h04};
		en = |({x[14:12], g} & {cfg[14:12], cfg[8]});
		if (g && frm_hashed) x[15:10] = frm_hash_index;
		return x;
	endfunction
	initial begin
		#2_000_000;
		fail_count++;
		test_done();
	end
	initial begin
		{rstn, reg_mem_mode, reg_rd, reg_wr, reg_addr, reg_wdata, cfg_mem_load, cfg_mem_data, hold} = '0;
		{accept_individual_hash, accept_station_addr, accept_all_ones_addr, dma_switch_cond} = '0;
		{frm_valid, frm_len, frm_fcs_bad, frm_dribble, frm_hashed, frm_hash_index} = '0;
		{frm_station_match, frm_all_ones, frm_wake, tx_event_set, tx_event_bits, tx_event_int} = '0;
		{buf_event_set, buf_event_bits, buf_event_int, miss_ovf, miss_count, col_ovf, col_count} = '0;
		repeat (2) @(negedge sys_clk);
		rstn = 1'b1;
		rdr(1'b1, 16'h0102);
		chk("cfg reset", d, 16'h0003);
		rdr(1'b0, 16'h0008);
		chk("queue idle", d, 16'h0000);
		rdr(1'b1, 16'h0126);
		chk("unmapped", d, 16'h0000);
		$display("test reset done");
		for (int i = 0; i < 48; i++) begin
			cfg = 16'($random(seed)) & 16'h7F80;
			if (!(cfg[9] | cfg[10])) cfg[7] = 1'b0;
			wrr(cfg);
			{frm_fcs_bad, frm_dribble, frm_hashed, frm_station_match, frm_all_ones, frm_wake,
				accept_individual_hash, accept_station_addr, accept_all_ones_addr, dma_switch_cond,
				frm_hash_index} = 16'($random(seed));
			frm_len = i < 8 ? lens[i] : 16'h0008 + (16'($random(seed)) & 16'h07FF);
			n = taken;
			frame();
			@(negedge sys_clk);
			e = exp_ev();
			lg = frm_len > 16'h05EE;
			xl = (lg ? 11'h5EE : frm_len[10:0]) - (cfg[11] ? 11'h000 : 11'h004);
			if (frm_len < 16'h0008) begin
				e = 16'h0004;
				en = 1'b0;
			end else begin
				for (int k = 0; k < 40 && taken == n; k++) @(negedge sys_clk);
				chk("desc", {2'b00, last}, {2'b00, cfg[7], cfg[9] | (cfg[10] & dma_switch_cond),
					e[8], xl});
			end
			if (!cfg[9]) begin
				chk("irq", {15'h0000, irq}, {15'h0000, en});
				if (en) begin
					rdr(i[0], i[0] ? 16'h0120 : 16'h0008);
					chk("queue", d, {e[15:6], 6'h04});
				end else begin
					rdr(1'b1, 16'h0124);
					chk("event", d, e);
				end
				if (frm_len >= 16'h0008) begin
					rdr(1'b1, 16'h0400);
					chk("status", d, e);
				end
				if (e[8]) begin
					rdr(1'b1, 16'h0402);
					chk("length", d, {5'h00, xl});
				end
			end
			rdr(1'b1, 16'h0124);
			if (!cfg[9]) chk("event cleared", d, 16'h0004);
			rdr(1'b1, 16'h0120);
			if (!cfg[9]) chk("queue drained", d, 16'h0000);
		end
		$display("test frames done");
		hold = 1'b1;
		wrr(16'h0000);
		n = taken;
		frm_len = 16'h0100;
		frame();
		frame();
		frm_valid = 1'b1;
		repeat (3) @(negedge sys_clk);
		chk("fifo full", {15'h0000, frm_ready}, 16'h0000);
		hold = 1'b0;
		frame();
		for (int k = 0; k < 60 && taken < n + 3; k++) @(negedge sys_clk);
		chk("drained", 16'(taken - n), 16'h0003);
		rdr(1'b1, 16'h0124);
		$display("test fifo done");
		for (int k = 0; k < 4; k++) q[k] = 16'($random(seed)) & 16'hFFC0;
		{tx_event_bits, buf_event_bits, miss_count, col_count} = {q[0][15:6], q[1][15:6],
			q[2][15:6], q[3][15:6]};
		{tx_event_set, tx_event_int, buf_event_set, buf_event_int, miss_ovf, col_ovf} = 6'h3F;
		@(negedge sys_clk);
		{tx_event_set, buf_event_set, miss_ovf, col_ovf} = 4'h0;
		@(negedge sys_clk);
		chk("irq sources", {15'h0000, irq}, 16'h0001);
		q[0][5:0] = 6'h08;
		q[1][5:0] = 6'h0C;
		q[2][5:0] = 6'h10;
		q[3][5:0] = 6'h12;
		q[4] = 16'h0000;
		for (int k = 0; k < 5; k++) begin
			rdr(1'b1, 16'h0120);
			chk("queue order", d, q[k]);
		end
		$display("test queue done");
		wrr(16'h0040);
		chk("skip pulse", {15'h0000, skip_frame}, 16'h0001);
		@(negedge sys_clk);
		wrr(16'h0240);
		chk("skip dma only", {15'h0000, skip_frame}, 16'h0000);
		rdr(1'b1, 16'h0102);
		chk("cfg read", d, 16'h0203);
		cfg_mem_load = 1'b1;
		cfg_mem_data = 16'hAAAA;
		@(negedge sys_clk);
		cfg_mem_load = 1'b0;
		rdr(1'b1, 16'h0102);
		chk("cfg load", d, 16'h2A83);
		rdr(1'b0, 16'h0102);
		chk("io cfg", d, 16'h0000);
		$display("test config done");
		test_done();
	end
endmodule
`default_nettype wire
